// file: shared/opp_pkg.sv
package opp_pkg;
    localparam int ADDR_W = 14;
    localparam int LO_W = 8;
    localparam int HI_W = 6;
    localparam int DATA_W = 8;
    localparam int MEM_DEPTH = 16384;
    localparam int LOCK_W = 2;
    localparam logic [1:0] SEL_RESERVED = 2'h0;
    localparam logic [1:0] SEL_VERSION = 2'h1;
    localparam logic [1:0] SEL_LOCK = 2'h2;
    localparam logic [1:0] SEL_MEMORY = 2'h3;
    localparam logic [7:0] ERASED_BYTE = 8'hff;
    localparam logic [1:0] LOCK_RESET = 2'h0;
    localparam logic [5:0] HI_ADDR_RESET = 6'h00;
    localparam logic [7:0] VERSION_BYTE0 = 8'h5a; // Arbitrary value
    localparam logic [7:0] VERSION_BYTE1 = 8'h01; // Arbitrary value
    typedef enum logic [1:0] {OPP_IDLE, OPP_ENTRY, OPP_ACTIVE, OPP_BARRED} opp_state_t;
endpackage : opp_pkg

// file: rtl/opp_mem.sv
`timescale 1ns/1ps
module opp_mem (
    // Clock
    input wire logic clock,
    // Access
    input wire logic wr_en,
    input wire logic [13:0] addr,
    input wire logic [7:0] wr_data,
    output logic [7:0] rd_data_ff
);
    logic [7:0] mem [0:opp_pkg::MEM_DEPTH-1];

    // OTP cells only lose ones when programmed; plain always since the fill also writes
    always @(posedge clock) begin
        if (wr_en) begin
            mem[addr] <= mem[addr] & wr_data;
        end
    end

    always_ff @(posedge clock) begin
        rd_data_ff <= mem[addr];
    end

    initial begin
        for (int i = 0; i < opp_pkg::MEM_DEPTH; i++) begin
            mem[i] = opp_pkg::ERASED_BYTE;
        end
    end
endmodule : opp_mem

// file: rtl/opp_port.sv
`timescale 1ns/1ps
// Notes on behaviour
// - The device answers only to the programmer's address, data and control pins.
// - Data moves over the bidirectional data port, the address port is input only.
// - Upper address bits are captured by the high address latch strobe and kept.
// - Access select 00 reserved, 01 version read, 10 lock bits, 11 memory byte.
// - Every read is governed by the read strobe; data is returned only under it.
// - Mode entry is decided from reset, store enable, access, latch, high latch, read, write, select and entry pins.
// - The write pulse strobe governs memory byte and lock bit writes.
// - At the entry select falling edge the write strobe and access pin levels are latched.
// - The address is 14 bits: low eight direct, upper six latched.
// - Once protection is programmed and the mode is left, entry is refused.
module opp_port (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Mode pins
    input wire logic reset_pin,
    input wire logic program_store_enable_pin,
    input wire logic external_access_supply_pin,
    input wire logic address_latch_pin,
    input wire logic mode_entry_select,
    // Access pins
    input wire logic high_address_latch_strobe,
    input wire logic access_select_lo,
    input wire logic access_select_hi,
    input wire logic read_access_strobe_n,
    input wire logic write_pulse_strobe_n,
    // Address port
    input wire logic [7:0] addr_port,
    // Data port
    input wire logic [7:0] data_in,
    output logic [7:0] data_out,
    output logic data_oe,
    // Status
    output logic write_pulse_strobe_mode,
    output logic [1:0] lock_level
);
    // Two-stage synchronisers on all pins
    localparam int NP = 26;
    logic [NP-1:0] pins_raw;
    logic [NP-1:0] s1_ff;
    logic [NP-1:0] s2_ff;
    assign pins_raw = {
        reset_pin,
        program_store_enable_pin,
        external_access_supply_pin,
        address_latch_pin,
        mode_entry_select,
        high_address_latch_strobe,
        access_select_lo,
        access_select_hi,
        read_access_strobe_n,
        write_pulse_strobe_n,
        addr_port,
        data_in
    };
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s1_ff <= '0;
            s2_ff <= '0;
        end else begin
            s1_ff <= pins_raw;
            s2_ff <= s1_ff;
        end
    end

    wire rst_s = s2_ff[25];
    wire program_store_enable_pin_s = s2_ff[24];
    wire ea_s = s2_ff[23];
    wire ale_s = s2_ff[22];
    wire sel_s = s2_ff[21];
    wire hale_s = s2_ff[20];
    wire [1:0] acc_s = {s2_ff[18], s2_ff[19]};
    wire rd_s_n = s2_ff[17];
    wire wr_s_n = s2_ff[16];
    wire [7:0] addr_s = s2_ff[15:8];
    wire [7:0] din_s = s2_ff[7:0];

    logic sel_d_ff;
    logic hale_d_ff;
    logic wr_d_ff;
    logic [5:0] hi_addr_ff;
    logic [1:0] lock_ff;
    logic wr_latched_ff;
    logic vpp_latched_ff;
    opp_pkg::opp_state_t state_ff, nxt_state;

    // Edge detectors on the synchronised pins
    wire sel_fall = sel_d_ff & ~sel_s;
    wire hale_fall = hale_d_ff & ~hale_s;
    wire wr_fall = wr_d_ff & ~wr_s_n;
    wire active = (state_ff == opp_pkg::OPP_ACTIVE);
    wire in_entry = (state_ff == opp_pkg::OPP_ENTRY);
    wire latch_now = in_entry & sel_fall;
    // Entry preconditions
    wire entry_ok = rst_s & ~program_store_enable_pin_s & ~ea_s & ~ale_s & ~hale_s & ~wr_s_n & ~rd_s_n
        & ~acc_s[1] & acc_s[0] & sel_s;
    // Leaving: reset released or store enable raised
    wire leave = ~rst_s | program_store_enable_pin_s;
    wire [13:0] full_addr = {hi_addr_ff, addr_s};
    wire sel_mem = acc_s == opp_pkg::SEL_MEMORY;
    wire sel_lock = acc_s == opp_pkg::SEL_LOCK;
    wire sel_ver = acc_s == opp_pkg::SEL_VERSION;
    wire sel_none = acc_s == opp_pkg::SEL_RESERVED;
    // Writes stay off unless both pins were low when the entry select fell
    wire pins_armed = ~wr_latched_ff & ~vpp_latched_ff;
    wire wr_pulse = active & pins_armed & wr_fall & ea_s;
    wire mem_wr = wr_pulse & sel_mem;
    wire lock_wr = wr_pulse & sel_lock;
    wire reading = active & ~rd_s_n & ~sel_none;
    wire [7:0] mem_q;
    // Version byte picked by the lowest address bit
    wire [7:0] ver_q = addr_s[0] ? opp_pkg::VERSION_BYTE1 : opp_pkg::VERSION_BYTE0;
    wire [7:0] lock_q = {6'h00, lock_ff};
    // Reserved code reads as zero and is never driven anyway
    wire [7:0] rd_mux = sel_mem ? mem_q : sel_lock ? lock_q : sel_ver ? ver_q : 8'h00;

    // Mode sequencer
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            opp_pkg::OPP_IDLE: begin
                if (lock_ff != opp_pkg::LOCK_RESET) begin
                    nxt_state = opp_pkg::OPP_BARRED;
                end else if (entry_ok) begin
                    nxt_state = opp_pkg::OPP_ENTRY;
                end
            end
            opp_pkg::OPP_ENTRY: begin
                if (leave) begin
                    nxt_state = opp_pkg::OPP_IDLE;
                end else if (sel_fall) begin
                    nxt_state = opp_pkg::OPP_ACTIVE;
                end
            end
            opp_pkg::OPP_ACTIVE: begin
                if (leave) begin
                    nxt_state = (lock_ff != opp_pkg::LOCK_RESET) ? opp_pkg::OPP_BARRED
                        : opp_pkg::OPP_IDLE;
                end
            end
            opp_pkg::OPP_BARRED: begin
                // Only a global reset lifts the bar
                nxt_state = opp_pkg::OPP_BARRED;
            end
            default: nxt_state = opp_pkg::OPP_IDLE;
        endcase
    end

    // State and edge history
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= opp_pkg::OPP_IDLE;
            sel_d_ff <= 1'b0;
            hale_d_ff <= 1'b0;
            wr_d_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            sel_d_ff <= sel_s;
            hale_d_ff <= hale_s;
            wr_d_ff <= wr_s_n;
        end
    end

    // Latched entry levels of write strobe and supply pin
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wr_latched_ff <= 1'b0;
            vpp_latched_ff <= 1'b0;
        end else if (latch_now) begin
            wr_latched_ff <= wr_s_n;
            vpp_latched_ff <= ea_s;
        end
    end

    // Upper address captured on strobe falling edge
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            hi_addr_ff <= opp_pkg::HI_ADDR_RESET;
        end else if (active && hale_fall) begin
            hi_addr_ff <= addr_s[5:0];
        end
    end

    // Lock bits only ever gain protection
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            lock_ff <= opp_pkg::LOCK_RESET;
        end else if (lock_wr) begin
            lock_ff <= lock_ff | din_s[1:0];
        end
    end

    // Program memory, erased at power-up
    opp_mem u_mem (
        .clock(clock),
        .wr_en(mem_wr),
        .addr(full_addr),
        .wr_data(din_s),
        .rd_data_ff(mem_q)
    );

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            // Port released while no strobed read is in progress
            data_out <= 8'h00;
            data_oe <= 1'b0;
        end else begin
            data_out <= reading ? rd_mux : 8'h00;
            data_oe <= reading;
        end
    end

    assign write_pulse_strobe_mode = active;
    assign lock_level = lock_ff;
endmodule : opp_port

// file: test/opp_port_assertions.sv
`timescale 1ns/1ps
module opp_port_assertions (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Watched ports
    input wire logic reset_pin,
    input wire logic access_select_lo,
    input wire logic access_select_hi,
    input wire logic read_access_strobe_n,
    input wire logic data_oe,
    input wire logic write_pulse_strobe_mode,
    input wire logic [1:0] lock_level
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    logic barred_ff;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) barred_ff <= 1'b0;
        else if (!write_pulse_strobe_mode && lock_level != 2'h0) barred_ff <= 1'b1;
    end
    sequence read_held;
        (!read_access_strobe_n)[*4];
    endsequence
    sequence read_live;
        (write_pulse_strobe_mode && !read_access_strobe_n && (access_select_hi || access_select_lo))[*6];
    endsequence
    chk_oe_released: assert property (read_access_strobe_n[*5] |-> !data_oe)
        else $error("data port driven without read strobe");
    chk_reserved_quiet: assert property ((!access_select_hi && !access_select_lo)[*5] |-> !data_oe)
        else $error("data port driven on reserved select");
    chk_read_answers: assert property ($fell(read_access_strobe_n) ##1 read_live |-> data_oe)
        else $error("read strobe not answered");
    chk_oe_stands: assert property (read_held ##0 data_oe |=> data_oe)
        else $error("read data dropped under strobe");
    chk_lock_held: assert property ((!write_pulse_strobe_mode)[*4] |-> $stable(lock_level))
        else $error("lock bits changed outside mode");
    chk_lock_grows: assert property ((lock_level & $past(lock_level)) == $past(lock_level))
        else $error("lock bit cleared");
    chk_barred_entry: assert property (barred_ff |-> !write_pulse_strobe_mode)
        else $error("mode entered after protection");
    chk_mode_drop: assert property ((!reset_pin)[*6] |-> !write_pulse_strobe_mode)
        else $error("mode held without reset pin");
endmodule : opp_port_assertions

// file: test/opp_write_pulse_strobe_model.sv
`timescale 1ns/1ps
module opp_write_pulse_strobe_model (
    // Clock and data port
    input wire logic clock,
    input wire logic [7:0] data_in,
    output logic [7:0] drv,
    // Pins
    output logic reset_pin,
    output logic program_store_enable_pin,
    output logic external_access_supply_pin,
    output logic address_latch_pin,
    output logic mode_entry_select,
    output logic high_address_latch_strobe,
    output logic access_select_hi,
    output logic access_select_lo,
    output logic read_access_strobe_n,
    output logic write_pulse_strobe_n,
    output logic [7:0] addr_port
);
    logic [9:0] pv = 10'h003;
    assign {reset_pin, program_store_enable_pin, external_access_supply_pin, address_latch_pin,
        mode_entry_select, high_address_latch_strobe, access_select_hi, access_select_lo,
        read_access_strobe_n, write_pulse_strobe_n} = pv;
    initial drv = 8'h00;
    initial addr_port = 8'h00;
    task automatic drive(input logic [9:0] v);
        @(posedge clock);
        pv <= v;
        repeat (6) @(posedge clock);
    endtask : drive
    task automatic enter();
        drive(10'h224);
        drive(10'h204);
        drive(10'h205);
        drive(10'h287);
    endtask : enter
    task automatic access(input logic [1:0] sel, input logic [13:0] a, input logic wr,
        input logic [7:0] d, output logic [7:0] q);
        logic [9:0] b;
        b = {6'b101000, sel, 2'b11};
        drive(b);
        addr_port <= {2'b00, a[13:8]};
        drive(b | 10'h010);
        drive(b);
        addr_port <= a[7:0];
        if (wr) begin
            drv <= d;
            drive(b & ~10'h001);
            drive(b);
        end
        drv <= ~d;
        drive(b & ~10'h002);
        @(negedge clock);
        q = data_in;
        drive(b);
    endtask : access
endmodule : opp_write_pulse_strobe_model

// file: test/opp_port_tb.sv
`timescale 1ns/1ps
module opp_port_tb;
    logic clock, rst_n, reset_pin, program_store_enable_pin, external_access_supply_pin;
    logic address_latch_pin, mode_entry_select, high_address_latch_strobe, access_select_hi;
    logic access_select_lo, read_access_strobe_n, write_pulse_strobe_n, data_oe, write_pulse_strobe_mode;
    logic [7:0] addr_port, data_in, data_out, drv, q;
    logic [1:0] lock_level;
    int miscompares = 0;
    int checks_done = 0;
    assign data_in = data_oe ? data_out : drv;
    opp_write_pulse_strobe_model opp_write_pulse_strobe_model_i (.clock, .data_in, .drv, .reset_pin,
        .program_store_enable_pin, .external_access_supply_pin, .address_latch_pin,
        .mode_entry_select, .high_address_latch_strobe, .access_select_hi, .access_select_lo,
        .read_access_strobe_n, .write_pulse_strobe_n, .addr_port);
    opp_port opp_port_i (.clock, .rst_n, .reset_pin, .program_store_enable_pin,
        .external_access_supply_pin, .address_latch_pin, .mode_entry_select,
        .high_address_latch_strobe, .access_select_lo, .access_select_hi, .read_access_strobe_n,
        .write_pulse_strobe_n, .addr_port, .data_in, .data_out, .data_oe, .write_pulse_strobe_mode, .lock_level);
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic summarize();
        $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : summarize
    task automatic t_memory();
        opp_write_pulse_strobe_model_i.access(opp_pkg::SEL_MEMORY, 14'h2a81, 1'b1, 8'h3c, q);
        check(q, 8'h3c);
        opp_write_pulse_strobe_model_i.access(opp_pkg::SEL_MEMORY, 14'h2a81, 1'b1, 8'hf0, q);
        check(q, 8'h30);
        opp_write_pulse_strobe_model_i.access(opp_pkg::SEL_MEMORY, 14'h0a81, 1'b0, 8'h00, q);
        check(q, opp_pkg::ERASED_BYTE);
    endtask : t_memory
    task automatic t_select();
        opp_write_pulse_strobe_model_i.access(opp_pkg::SEL_VERSION, 14'h0000, 1'b0, 8'h00, q);
        check(q, opp_pkg::VERSION_BYTE0);
        opp_write_pulse_strobe_model_i.access(opp_pkg::SEL_VERSION, 14'h0001, 1'b0, 8'h00, q);
        check(q, opp_pkg::VERSION_BYTE1);
        opp_write_pulse_strobe_model_i.access(opp_pkg::SEL_RESERVED, 14'h2a81, 1'b0, 8'h66, q);
        check(q, 8'h99);
    endtask : t_select
    task automatic t_lock();
        opp_write_pulse_strobe_model_i.access(opp_pkg::SEL_LOCK, 14'h0000, 1'b1, 8'h01, q);
        check({6'h00, lock_level}, 8'h01);
        check(q, 8'h01);
        opp_write_pulse_strobe_model_i.drive(10'h003);
        opp_write_pulse_strobe_model_i.enter();
        check({7'h00, write_pulse_strobe_mode}, 8'h00);
    endtask : t_lock
    initial begin
        rst_n = 1'b0;
        repeat (16) @(posedge clock);
        rst_n <= 1'b1;
        check({7'h00, write_pulse_strobe_mode}, 8'h00);
        opp_write_pulse_strobe_model_i.enter();
        check({7'h00, write_pulse_strobe_mode}, 8'h01);
        t_memory();
        t_select();
        t_lock();
        summarize();
    end
    initial begin
        repeat (5000) @(posedge clock);
        miscompares++;
        summarize();
    end
endmodule : opp_port_tb
bind opp_port opp_port_assertions opp_port_assertions_i (.clock, .rst_n, .reset_pin,
    .access_select_lo, .access_select_hi, .read_access_strobe_n, .data_oe, .write_pulse_strobe_mode,
    .lock_level);
